// ### flash_array.sv
// flash_array: byte-wide storage for the whole 8 Mbit array.
// assumes one writer and an asynchronous read port.
`timescale 1ns/1ps
`default_nettype none
module flash_array
    import flash_seq_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);

    // ==========================================================
    // storage; contents survive reset like real cells
    logic [7:0] mem [0:ARRAY_BYTES-1];

    // one byte written per cycle
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : flash_array
`default_nettype wire

// ### flash_seq.sv
// flash_seq: program/erase sequencer with polling, block protection,
// cycle-kind detection and a multiplexed programmer port, on APB.
// assumes pclk at 50 MHz; all pins are asynchronous to pclk.
//
// Contract
// - 4 KB sectors, 16 sectors per 64 KB block
// - sector/block erase touches only its region
// - chip erase clears whole array
// - program one byte; host erases first
// - program code then one data byte starts self-timed program
// - erase codes start matching self-timed erase
// - erase needs no preprogramming
// - busy reads show inverted bit7, toggling bit6
// - boot block locked by pin or register
// - other blocks locked by pin or register
// - in-system cycle kind detected automatically
// - hub cycles compare four strap id pins
// - five input pins into readable register
// - programmer: 11-bit address, 8-bit data port
// - row latched falling, column latched rising
// - reset or init pin returns standby
// - frame pin aborts hub cycle in progress
`timescale 1ns/1ps
`default_nettype none
module flash_seq
    import flash_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic init_n,
    input wire logic interface_select,
    input wire logic boot_block_lock_n,
    input wire logic array_protect_n,
    input wire logic hub_cycle_frame,
    input wire logic [3:0] chip_strap_id,
    input wire logic [4:0] general_input_pins,
    input wire logic [10:0] mux_addr,
    input wire logic row_col_sel,
    input wire logic pp_we_n,
    input wire logic pp_oe_n,
    input wire logic [7:0] pp_data_in,
    output logic [7:0] pp_data_out,
    output logic pp_data_oe
);

    // ==========================================================
    // helper functions
    // lock state of one block: boot block has its own pin
    function automatic logic blk_prot(input logic [BLK_W-1:0] blk,
                                      input logic [15:0] lock,
                                      input logic tbl_n, input logic wp_n);
        blk_prot = (blk == BOOT_BLOCK) ? (~tbl_n | lock[blk]) : (~wp_n | lock[blk]);
    endfunction : blk_prot

    function automatic logic any_prot(input logic [15:0] lock,
                                      input logic tbl_n, input logic wp_n);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            r = r | blk_prot(BLK_W'(i), lock, tbl_n, wp_n);
        end
        any_prot = r;
    endfunction : any_prot

    function automatic op_t op_of(input logic [7:0] code);
        op_of = (code == CMD_PROGRAM) ? OP_PROG :
                (code == CMD_SECTOR) ? OP_SECTOR :
                (code == CMD_BLOCK) ? OP_BLOCK :
                (code == CMD_CHIP) ? OP_CHIP : OP_NONE;
    endfunction : op_of

    // ==========================================================
    // pin synchronisers
    pins_t pins_raw, sync1_q, s, prev_q;
    assign pins_raw = '{init_n, interface_select, boot_block_lock_n, array_protect_n,
                        hub_cycle_frame, chip_strap_id, general_input_pins, mux_addr,
                        row_col_sel, pp_we_n, pp_oe_n, pp_data_in};

    // idle-high reset value keeps strobes inactive; prev_q only sees s
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '1;
            s <= '1;
            prev_q <= '1;
        end else begin
            sync1_q <= pins_raw;
            s <= sync1_q;
            prev_q <= s;
        end
    end

    wire logic rc_fell = prev_q.row_col_sel & ~s.row_col_sel;
    wire logic rc_rose = ~prev_q.row_col_sel & s.row_col_sel;
    wire logic we_fell = prev_q.we_n & ~s.we_n;
    wire logic oe_fell = prev_q.oe_n & ~s.oe_n;
    wire logic frame_rose = ~prev_q.hub_cycle_frame & s.hub_cycle_frame;
    wire logic soft_rst = ~s.init_n;

    // ==========================================================
    // strap capture: mode sampled only while settling after reset
    logic pp_mode_q;
    logic [1:0] strap_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_q <= 2'h0;
            pp_mode_q <= 1'b0;
        end else if (strap_cnt_q != STRAP_SETTLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            pp_mode_q <= s.interface_select;
        end
    end

    // ==========================================================
    // programmer address latches
    logic [10:0] row_q, col_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_q <= 11'h000;
            col_q <= 11'h000;
        end else begin
            if (rc_fell) row_q <= s.mux_addr;
            if (rc_rose) col_q <= s.mux_addr;
        end
    end
    // unused top row bits ignored
    wire logic [ADDR_W-1:0] pp_addr = {row_q[8:0], col_q};

    // ==========================================================
    // apb decode
    wire logic setup = psel & ~penable;
    wire logic acc_wr = psel & penable & pready & pwrite;
    wire logic mapped = (paddr == REG_ADDR) | (paddr == REG_DATA) | (paddr == REG_CMD) |
                        (paddr == REG_STATUS) | (paddr == REG_LOCK) | (paddr == REG_GPI) |
                        (paddr == REG_CYCLE);

    // ==========================================================
    // software registers and cycle tracking
    logic [ADDR_W-1:0] addr_q;
    logic [15:0] lock_q;
    logic [4:0] gpi_q;
    logic armed_q, hub_kind_q, reject_q, prog_armed_q, tog_q;
    logic [3:0] cyc_id_q;
    seq_state_t state_q;
    wire logic busy = (state_q != S_IDLE);
    wire logic idle = ~busy;

    wire logic [3:0] cyc_start = pwdata[CYC_START_LSB +: 4];
    wire logic cyc_valid = (cyc_start == START_LPC) | (cyc_start == START_HUB);
    wire logic cyc_wr = acc_wr & (paddr == REG_CYCLE) & ~pp_mode_q;
    // hub cycles must name this chip; lpc cycles always do
    wire logic cyc_ok = armed_q & (~hub_kind_q | (cyc_id_q == s.chip_strap_id));
    wire logic apb_cmd = acc_wr & (paddr == REG_CMD) & ~pp_mode_q & cyc_ok;
    wire logic apb_data = acc_wr & (paddr == REG_DATA) & ~pp_mode_q & cyc_ok;
    wire logic pp_wr = pp_mode_q & we_fell;

    // ==========================================================
    // request assembly from either port
    wire logic cmd_wr = apb_cmd | (pp_wr & ~prog_armed_q);
    wire logic data_wr = (apb_data | pp_wr) & prog_armed_q;
    wire logic [7:0] in_byte = pp_mode_q ? s.data : pwdata[7:0];
    wire op_t cmd_op = op_of(in_byte);
    req_t req;
    assign req.op = data_wr ? OP_PROG : (cmd_wr && cmd_op != OP_PROG) ? cmd_op : OP_NONE;
    assign req.addr = pp_mode_q ? pp_addr : addr_q;
    assign req.data = in_byte;

    wire logic [BLK_W-1:0] req_blk = req.addr[ADDR_W-1 -: BLK_W];
    wire logic req_prot = (req.op == OP_CHIP) ?
                          any_prot(lock_q, s.boot_block_lock_n, s.array_protect_n) :
                          blk_prot(req_blk, lock_q, s.boot_block_lock_n, s.array_protect_n);
    wire logic launch_req = idle & ~soft_rst & (req.op != OP_NONE);
    wire logic launch_go = launch_req & ~req_prot;
    wire logic [ADDR_W-1:0] erase_mask = (req.op == OP_SECTOR) ? SECTOR_MASK :
                                         (req.op == OP_BLOCK) ? BLOCK_MASK : CHIP_LAST;
    wire logic st_wr = acc_wr & (paddr == REG_STATUS);

    // register writes; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= '0;
            lock_q <= LOCK_RST;
            gpi_q <= 5'h00;
            reject_q <= 1'b0;
        end else begin
            gpi_q <= s.general_input_pins;
            if (acc_wr && paddr == REG_ADDR) addr_q <= pwdata[ADDR_W-1:0];
            if (acc_wr && paddr == REG_LOCK) lock_q <= pwdata[15:0];
            reject_q <= (launch_req & req_prot) | (reject_q & ~(st_wr & pwdata[ST_REJECT]));
        end
    end

    // cycle framing: frame pin aborts an armed hub cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
            hub_kind_q <= 1'b0;
            cyc_id_q <= 4'h0;
        end else if (soft_rst) begin
            armed_q <= 1'b0;
        end else if (cyc_wr) begin
            armed_q <= cyc_valid;
            hub_kind_q <= (cyc_start == START_HUB);
            cyc_id_q <= pwdata[CYC_ID_LSB +: 4];
        end else if (apb_cmd | apb_data | (frame_rose & hub_kind_q)) begin
            armed_q <= 1'b0;
        end
    end

    // program code arms; the next byte written is programmed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_armed_q <= 1'b0;
        end else if (soft_rst || data_wr) begin
            prog_armed_q <= 1'b0;
        end else if (cmd_wr && cmd_op == OP_PROG && idle) begin
            prog_armed_q <= 1'b1;
        end
    end

    // ==========================================================
    // sequencer
    logic [ADDR_W-1:0] ptr_q, last_q;
    logic [9:0] cnt_q;
    logic [7:0] pdata_q;
    logic tgt7_q;
    op_t op_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            op_q <= OP_NONE;
            ptr_q <= '0;
            last_q <= '0;
            cnt_q <= 10'h000;
            pdata_q <= 8'h00;
            tgt7_q <= 1'b0;
        end else if (soft_rst) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: if (launch_go) begin
                    op_q <= req.op;
                    if (req.op == OP_PROG) begin
                        state_q <= S_PROG;
                        ptr_q <= req.addr;
                        pdata_q <= req.data;
                        tgt7_q <= req.data[7];
                        cnt_q <= PROG_CYCLES - 10'h001;
                    end else begin
                        state_q <= S_ERASE;
                        ptr_q <= req.addr & ~erase_mask;
                        last_q <= req.addr | erase_mask;
                        tgt7_q <= ERASED_BYTE[7];
                    end
                end
                S_PROG: begin
                    cnt_q <= cnt_q - 10'h001;
                    if (cnt_q == 10'h000) state_q <= S_IDLE;
                end
                S_ERASE: begin
                    ptr_q <= ptr_q + 20'h0_0001;
                    if (ptr_q == last_q) state_q <= S_IDLE;
                end
            endcase
        end
    end

    // erase overwrites every byte, so old contents never matter
    wire logic arr_we = ~soft_rst & (((state_q == S_PROG) & (cnt_q == 10'h000)) |
                                     (state_q == S_ERASE));
    wire logic [7:0] arr_wdata = (state_q == S_ERASE) ? ERASED_BYTE : pdata_q;
    wire logic [7:0] arr_rdata;

    flash_array u_array (
        .clk(pclk),
        .we(arr_we),
        .waddr(ptr_q),
        .wdata(arr_wdata),
        .raddr(req.addr),
        .rdata(arr_rdata)
    );

    // ==========================================================
    // read data and polling
    wire logic [7:0] rd_val = busy ? {~tgt7_q, tog_q, 6'h00} : arr_rdata;
    wire logic apb_rd_data = setup & ~pwrite & (paddr == REG_DATA) & ~pp_mode_q;
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_BUSY] = busy;
        status_word[ST_REJECT] = reject_q;
        status_word[ST_PP_MODE] = pp_mode_q;
        status_word[ST_HUB_KIND] = hub_kind_q;
        status_word[ST_ARMED] = armed_q;
    end
    wire logic [31:0] rd_mux =
        (paddr == REG_ADDR) ? {12'h000, addr_q} :
        (paddr == REG_DATA) ? {24'h00_0000, rd_val} :
        (paddr == REG_STATUS) ? status_word :
        (paddr == REG_LOCK) ? {16'h0000, lock_q} :
        (paddr == REG_GPI) ? {27'h000_0000, gpi_q} :
        (paddr == REG_CYCLE) ? {24'h00_0000, cyc_id_q, 3'h0, hub_kind_q} : 32'h0000_0000;

    // toggle advances once per polled read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_q <= 1'b0;
        end else if (busy && (apb_rd_data || (pp_mode_q && oe_fell))) begin
            tog_q <= ~tog_q;
        end
    end

    // zero-wait slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) prdata <= rd_mux;
        end
    end

    // programmer data port; oe released while writing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pp_data_out <= 8'h00;
            pp_data_oe <= 1'b0;
        end else begin
            pp_data_oe <= pp_mode_q & ~s.oe_n & s.we_n;
            if (!s.oe_n) pp_data_out <= rd_val;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    poll_bits_a: assert property (apb_rd_data && busy |=> prdata[7] == ~tgt7_q && prdata[5:0] == 6'h00)
        else $error("busy read lacks polling bits");
    boot_lock_a: assert property (launch_req && req.op != OP_CHIP && req_blk == BOOT_BLOCK && !s.boot_block_lock_n |=> !busy)
        else $error("locked boot block started");
    array_lock_a: assert property (launch_req && req.op != OP_CHIP && req_blk != BOOT_BLOCK && lock_q[req_blk] |=> !busy)
        else $error("locked block started");
    prot_keep_a: assert property (launch_req && req_prot |=> state_q == S_IDLE ##1 !arr_we)
        else $error("protected region written");
    erase_span_a: assert property (launch_go && req.op == OP_SECTOR |=> (last_q - ptr_q) == SECTOR_MASK)
        else $error("sector span wrong");
    chip_span_a: assert property (launch_go && req.op == OP_CHIP |=> ptr_q == '0 && last_q == CHIP_LAST)
        else $error("chip erase span wrong");
    erase_data_a: assert property (state_q == S_ERASE && arr_we |-> arr_wdata == ERASED_BYTE && ptr_q <= last_q)
        else $error("erase wrote outside region");
    prog_time_a: assert property (launch_go && req.op == OP_PROG |=> busy [*8])
        else $error("program ended too soon");
    hub_id_a: assert property (acc_wr && paddr == REG_CMD && hub_kind_q && cyc_id_q != s.chip_strap_id |-> !apb_cmd)
        else $error("foreign hub cycle accepted");
    row_latch_a: assert property (rc_fell |=> row_q == $past(s.mux_addr))
        else $error("row address not latched");
    init_idle_a: assert property (soft_rst |=> state_q == S_IDLE && !prog_armed_q)
        else $error("init did not return standby");

endmodule : flash_seq
`default_nettype wire

// ### flash_seq_pkg.sv
// flash_seq_pkg: constants, types and register map of the sequencer.
// assumes a 50 MHz APB clock and a byte-wide 8 Mbit array behind it.
package flash_seq_pkg;

    // ==========================================================
    // array geometry
    localparam int ADDR_W = 20;
    localparam int BLK_W = 4;
    localparam int NUM_BLOCKS = 16;
    localparam int ARRAY_BYTES = 1048576;
    localparam logic [ADDR_W-1:0] SECTOR_MASK = 20'h0_0fff; // 4 Kbyte sector
    localparam logic [ADDR_W-1:0] BLOCK_MASK = 20'h0_ffff; // 64 Kbyte block
    localparam logic [ADDR_W-1:0] CHIP_LAST = 20'hf_ffff;
    localparam logic [BLK_W-1:0] BOOT_BLOCK = 4'hf; // top boot block
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 18000;
    localparam int PROG_CYCLES_I = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] PROG_CYCLES = 10'(PROG_CYCLES_I);
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [11:0] REG_ADDR = 12'h000;
    localparam logic [11:0] REG_DATA = 12'h004;
    localparam logic [11:0] REG_CMD = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [11:0] REG_LOCK = 12'h010;
    localparam logic [11:0] REG_GPI = 12'h014;
    localparam logic [11:0] REG_CYCLE = 12'h018;

    // status fields
    localparam int ST_BUSY = 0;
    localparam int ST_REJECT = 1;
    localparam int ST_PP_MODE = 2;
    localparam int ST_HUB_KIND = 3;
    localparam int ST_ARMED = 4;
    // cycle register fields
    localparam int CYC_START_LSB = 0;
    localparam int CYC_ID_LSB = 4;
    localparam logic [3:0] START_LPC = 4'h0;
    localparam logic [3:0] START_HUB = 4'hd;
    localparam logic [15:0] LOCK_RST = 16'h0000;

    // command codes
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_BLOCK = 8'h50;
    localparam logic [7:0] CMD_CHIP = 8'h10;

    typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECTOR, OP_BLOCK, OP_CHIP} op_t;
    typedef enum logic [1:0] {S_IDLE, S_PROG, S_ERASE} seq_state_t;

    // pins from outside the clock domain
    typedef struct packed {
        logic init_n;
        logic interface_select;
        logic boot_block_lock_n;
        logic array_protect_n;
        logic hub_cycle_frame;
        logic [3:0] chip_strap_id;
        logic [4:0] general_input_pins;
        logic [10:0] mux_addr;
        logic row_col_sel;
        logic we_n;
        logic oe_n;
        logic [7:0] data;
    } pins_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } req_t;

endpackage : flash_seq_pkg

// ### flash_seq_test.sv
// flash_seq_test: self-checking bench for flash_seq.
// assumes host_bus_model as far side; fixed seed.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module flash_seq_test
    import flash_seq_pkg::*;
;
    logic pclk, presetn, init_n, interface_select, boot_block_lock_n, array_protect_n;
    logic hub_cycle_frame, psel, penable, pwrite, pready, pslverr, row_col_sel;
    logic pp_we_n, pp_oe_n, pp_data_oe, e, tn, wn, oe, rx;
    logic [3:0] chip_strap_id;
    logic [4:0] general_input_pins;
    logic [10:0] mux_addr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, q2, g, rq;
    logic [7:0] pp_data_in, pp_data_out, b0, b1, d8;
    logic [19:0] a0, a1, ta;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;

    flash_seq i_flash_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .init_n(init_n), .interface_select(interface_select),
        .boot_block_lock_n(boot_block_lock_n), .array_protect_n(array_protect_n),
        .hub_cycle_frame(hub_cycle_frame), .chip_strap_id(chip_strap_id),
        .general_input_pins(general_input_pins), .mux_addr(mux_addr),
        .row_col_sel(row_col_sel), .pp_we_n(pp_we_n), .pp_oe_n(pp_oe_n),
        .pp_data_in(pp_data_in), .pp_data_out(pp_data_out), .pp_data_oe(pp_data_oe));
    host_bus_model i_host_bus_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mux_addr(mux_addr), .row_col_sel(row_col_sel),
        .pp_we_n(pp_we_n), .pp_oe_n(pp_oe_n), .pp_data_in(pp_data_in),
        .pp_data_out(pp_data_out), .pp_data_oe(pp_data_oe));

    // ==========================================================
    // clock and hang guard; run needs about 6k cycles
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            test_done();
        end
    end

    // ==========================================================
    // bus helpers
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host_bus_model.xfer(1'b1, a, d, rq, rx);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        i_host_bus_model.xfer(1'b0, a, 32'h0000_0000, r, rx);
    endtask : rd
    // one lpc arming write per command
    task automatic arm_cmd(input logic [19:0] a, input logic [7:0] c);
        wr(REG_ADDR, {12'h000, a});
        wr(REG_CYCLE, {28'h000_0000, START_LPC});
        wr(REG_CMD, {24'h00_0000, c});
    endtask : arm_cmd
    task automatic prog(input logic [19:0] a, input logic [7:0] b);
        arm_cmd(a, CMD_PROGRAM);
        wr(REG_CYCLE, {28'h000_0000, START_LPC});
        wr(REG_DATA, {24'h00_0000, b});
    endtask : prog
    task automatic wait_idle;
        do rd(REG_STATUS, rq); while (rq[ST_BUSY] !== 1'b0);
    endtask : wait_idle
    function automatic logic exp_reject(logic [19:0] a, logic [15:0] lk, logic t, logic w);
        return ((a[19:16] == BOOT_BLOCK) ? !t : !w) || lk[a[19:16]];
    endfunction : exp_reject
    task automatic test_done;
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        init_n = 1'b1;
        interface_select = 1'b0;
        boot_block_lock_n = 1'b1;
        array_protect_n = 1'b1;
        hub_cycle_frame = 1'b0;
        chip_strap_id = 4'h9;
        general_input_pins = 5'h00;
        void'($urandom(45));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_LOCK, q);
        `CHK("lock rst", {16'h0000, LOCK_RST}, q)
        i_host_bus_model.xfer(1'b0, 12'h0fc, 32'h0000_0000, q, e);
        `CHK("unmapped", 1'b1, e)
        g = $urandom;
        general_input_pins <= g[4:0];
        repeat (5) @(posedge pclk);
        rd(REG_GPI, q);
        `CHK("gpi", g[4:0], q[4:0])
        // two bytes across a sector boundary, the first polled while busy
        a0 = {4'h6, 4'($urandom_range(14, 1)), 12'($urandom)};
        a1 = (a0 | SECTOR_MASK) + 20'h0_0001;
        b0 = 8'($urandom_range(254));
        b1 = 8'($urandom_range(254));
        wr(REG_LOCK, 32'h0000_0020);
        prog(a0, b0);
        rd(REG_DATA, q);
        `CHK("poll", {~b0[7], q[6], 6'h00}, q[7:0])
        rd(REG_DATA, q2);
        `CHK("toggle", {~b0[7], ~q[6], 6'h00}, q2[7:0])
        wait_idle();
        rd(REG_DATA, q);
        `CHK("prog", b0, q[7:0])
        prog(a1, b1);
        wait_idle();
        arm_cmd(a0, CMD_SECTOR);
        wait_idle();
        rd(REG_DATA, q);
        `CHK("erased", ERASED_BYTE, q[7:0])
        wr(REG_ADDR, {12'h000, a1});
        rd(REG_DATA, q);
        `CHK("neighbour", b1, q[7:0])
        // refused: pin locks, register lock, block and chip erase
        for (int i = 0; i < 4; i++) begin
            tn = (i != 1);
            wn = (i != 0);
            boot_block_lock_n <= tn;
            array_protect_n <= wn;
            ta = (i == 1) ? 20'hf_0123 : (i == 2) ? 20'h5_0040 : a1;
            repeat (4) @(posedge pclk);
            if (i < 2) prog(ta, 8'h00);
            else arm_cmd(ta, (i == 3) ? CMD_CHIP : CMD_BLOCK);
            rd(REG_STATUS, q);
            `CHK("reject", {(i == 3) | exp_reject(ta, 16'h0020, tn, wn), 1'b0}, q[1:0])
            wr(REG_STATUS, 32'h0000_0002);
        end
        wr(REG_ADDR, {12'h000, a1});
        rd(REG_DATA, q);
        `CHK("kept", b1, q[7:0])
        // hub: strap mismatch ignored, frame cancels arming
        wr(REG_CYCLE, {24'h00_0000, 4'h3, START_HUB});
        wr(REG_CMD, {24'h00_0000, CMD_SECTOR});
        rd(REG_STATUS, q);
        `CHK("id miss", 1'b0, q[ST_BUSY])
        wr(REG_CYCLE, {24'h00_0000, 4'h9, START_HUB});
        rd(REG_CYCLE, q);
        `CHK("hub kind", 5'h13, {q[7:4], q[0]})
        hub_cycle_frame <= 1'b1;
        repeat (5) @(posedge pclk);
        hub_cycle_frame <= 1'b0;
        rd(REG_STATUS, q);
        `CHK("abort", 1'b0, q[ST_ARMED])
        // init pin aborts a program
        prog(a0, 8'h5a);
        rd(REG_STATUS, q);
        `CHK("busy", 1'b1, q[ST_BUSY])
        init_n <= 1'b0;
        repeat (5) @(posedge pclk);
        init_n <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(REG_STATUS, q);
        `CHK("init", 1'b0, q[ST_BUSY])
        // programmer mode via reset
        interface_select <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(REG_STATUS, q);
        `CHK("pp mode", 1'b1, q[ST_PP_MODE])
        i_host_bus_model.pp_addr(a1[19:11], a1[10:0]);
        i_host_bus_model.pp_read(d8, oe);
        `CHK("pp data", b1, d8)
        `CHK("pp oe", 1'b1, oe)
        test_done();
    end
endmodule : flash_seq_test
`default_nettype wire

// ### host_bus_model.sv
// host_bus_model: APB master and programmer port driver.
// assumes tasks are called just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import flash_seq_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [10:0] mux_addr,
    output logic row_col_sel,
    output logic pp_we_n,
    output logic pp_oe_n,
    output logic [7:0] pp_data_in,
    input wire logic [7:0] pp_data_out,
    input wire logic pp_data_oe
);
    // ==========================================================
    // idle levels
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        mux_addr = 11'h000;
        row_col_sel = 1'b1;
        pp_we_n = 1'b1;
        pp_oe_n = 1'b1;
        pp_data_in = 8'h00;
    end

    // data lines churn while unused
    always @(posedge pclk) pp_data_in <= pp_data_in + 8'h01;

    // ==========================================================
    // one APB transfer, held until pready; only the bench timeout ends a wait
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // ==========================================================
    // row latched on fall, column on rise
    task automatic pp_addr(input logic [8:0] row, input logic [10:0] col);
        mux_addr <= {2'b00, row};
        repeat (4) @(posedge pclk);
        row_col_sel <= 1'b0;
        repeat (4) @(posedge pclk);
        mux_addr <= col;
        repeat (4) @(posedge pclk);
        row_col_sel <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : pp_addr

    // oe low long enough to pass the synchronisers
    task automatic pp_read(output logic [7:0] q, output logic oe);
        pp_oe_n <= 1'b0;
        repeat (8) @(posedge pclk);
        q = pp_data_out;
        oe = pp_data_oe;
        pp_oe_n <= 1'b1;
    endtask : pp_read
endmodule : host_bus_model
`default_nettype wire
